/* File: src/pbsc_pkg.sv */
// Shared types and constants for the pipelined burst SRAM control block
package pbsc_pkg;

    // ==========================================================
    // Geometry
    localparam int PBSC_DATA_W = 32;
    localparam int PBSC_LANES = 4;
    localparam int PBSC_LANE_W = 8;
    localparam int PBSC_ADDR_W = 17;
    localparam int PBSC_BURST_W = 2;

    // ==========================================================
    // Reset values and lane masks
    localparam logic [1:0] PBSC_BEAT_RST = 2'h0;
    localparam logic [16:0] PBSC_ADDR_RST = 17'h00000;
    localparam logic [31:0] PBSC_DATA_RST = 32'h00000000;
    localparam logic [3:0] PBSC_LANE_NONE = 4'h0;
    localparam logic [3:0] PBSC_LANE_ALL = 4'hf;

    // ==========================================================
    // Cycle types decoded at each clock edge
    typedef enum logic [2:0] {
        PBSC_DESELECT,
        PBSC_BEGIN,
        PBSC_CONTINUE,
        PBSC_SUSPEND
    } pbsc_cycle_t;

    // Synchronous control group as sampled on the clock
    typedef struct packed {
        logic primary_select_n;
        logic depth_select_hi;
        logic depth_select_lo_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic lane_write_enable_n;
        logic [3:0] byte_lane_write_n;
    } pbsc_ctrl_t;

    // Access handed to the array
    typedef struct packed {
        logic active;
        logic write;
        logic [3:0] lanes;
        logic [16:0] addr;
    } pbsc_access_t;

endpackage

/* File: src/pbsc_burst_counter.sv */
// Two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
module pbsc_burst_counter
    import pbsc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic i_advance,
    input wire logic i_linear,
    input wire logic [1:0] i_start,
    output logic [1:0] o_low_addr
);

    // ==========================================================
    // Counter state
    logic [1:0] start_ff;
    logic [1:0] beat_ff;
    logic [1:0] nxt_start;
    logic [1:0] nxt_beat;

    // A new strobe restarts the beat count from the external start
    always_comb begin
        nxt_start = start_ff;
        nxt_beat = beat_ff;
        if (i_load) begin
            nxt_start = i_start;
            nxt_beat = PBSC_BEAT_RST;
        end else if (i_advance) begin
            nxt_beat = beat_ff + 2'h1; // Wraps after four beats
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            start_ff <= PBSC_BEAT_RST;
            beat_ff <= PBSC_BEAT_RST;
        end else begin
            start_ff <= nxt_start;
            beat_ff <= nxt_beat;
        end
    end

    // Linear adds modulo four, interleaved XORs the beat count.
    // Taken from the next values so a continue uses the next address
    // in its own cycle, and a suspend the current one.
    assign o_low_addr = i_linear ? (nxt_start + nxt_beat)
                                 : (nxt_start ^ nxt_beat);

endmodule // pbsc_burst_counter

/* File: src/pbsc_sram_control.sv */
// Control logic of a 32-bit pipelined burst synchronous static RAM
`timescale 1ns/1ps

module pbsc_sram_control
    import pbsc_pkg::*;
#(
    parameter int DEPTH = 131072
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_primary_select_n,
    input wire logic i_depth_select_hi,
    input wire logic i_depth_select_lo_n,
    input wire logic i_proc_addr_strobe_n,
    input wire logic i_ctrl_addr_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic i_global_write_n,
    input wire logic i_lane_write_enable_n,
    input wire logic [3:0] i_byte_lane_write_n,
    input wire logic [16:0] i_address_in,
    input wire logic i_burst_order_select,
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    input wire logic [31:0] i_data_lane,
    output logic [31:0] o_data_lane,
    output logic [3:0] o_data_lane_oe,
    output logic o_low_power,
    output logic [2:0] o_cycle_type
);

    // ==========================================================
    // Decode of the sampled control group
    pbsc_ctrl_t ctl;
    pbsc_cycle_t cycle;
    logic all_sel;
    logic wr_req;
    logic [3:0] wr_lanes;
    logic load;

    assign ctl = '{i_primary_select_n, i_depth_select_hi,
                   i_depth_select_lo_n, i_proc_addr_strobe_n,
                   i_ctrl_addr_strobe_n, i_burst_advance_n,
                   i_global_write_n, i_lane_write_enable_n,
                   i_byte_lane_write_n};

    // Lanes written this cycle; global write overrides byte lanes
    function automatic logic [3:0] lanes_of(input pbsc_ctrl_t c);
        if (!c.global_write_n)
            return PBSC_LANE_ALL;
        else if (!c.lane_write_enable_n)
            return ~c.byte_lane_write_n;
        else
            return PBSC_LANE_NONE;
    endfunction

    assign wr_lanes = lanes_of(ctl);
    assign wr_req = |wr_lanes;
    assign all_sel = !ctl.primary_select_n && ctl.depth_select_hi
                     && !ctl.depth_select_lo_n;

    // Cycle type; proc strobe is blocked when primary select is high
    always_comb begin
        cycle = PBSC_SUSPEND;
        if (ctl.primary_select_n && !ctl.ctrl_addr_strobe_n)
            cycle = PBSC_DESELECT;
        else if (!ctl.primary_select_n && !ctl.proc_addr_strobe_n)
            cycle = all_sel ? PBSC_BEGIN : PBSC_DESELECT;
        else if (!ctl.ctrl_addr_strobe_n)
            cycle = all_sel ? PBSC_BEGIN : PBSC_DESELECT;
        else if (!ctl.burst_advance_n)
            cycle = PBSC_CONTINUE;
        else
            cycle = PBSC_SUSPEND;
    end

    assign load = (cycle == PBSC_BEGIN);

    // ==========================================================
    // Sleep: register updates are gated by the sleep request and the pending-sleep state
    logic sleep_ff;
    logic nxt_sleep;
    logic run;

    // Async sleep wins; after release wait for a new access
    always_comb begin
        nxt_sleep = sleep_ff;
        if (load)
            nxt_sleep = 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_reset_n
                or posedge i_sleep_request) begin
        if (!i_reset_n)
            sleep_ff <= 1'b0;
        else if (i_sleep_request)
            sleep_ff <= 1'b1;
        else
            sleep_ff <= nxt_sleep;
    end

    // Bursts and suspends do nothing while asleep; only a begin wakes
    assign run = !i_sleep_request && (!sleep_ff || load);

    // ==========================================================
    // Address and access registers
    logic [16:0] base_ff;
    logic [16:0] nxt_base;
    logic [1:0] low_addr;
    logic acc_ff;
    logic nxt_acc;
    logic rd_ff;
    logic nxt_rd;
    logic [16:0] cur_addr;
    logic [16:0] addr_now;

    pbsc_burst_counter u_burst (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_load(run && load),
        .i_advance(run && acc_ff && cycle == PBSC_CONTINUE),
        .i_linear(!i_burst_order_select),
        .i_start(i_address_in[1:0]),
        .o_low_addr(low_addr)
    );

    assign cur_addr = {base_ff[16:2], low_addr};
    // Address used this cycle: external on begin, else counter view
    assign addr_now = load ? i_address_in : cur_addr;

    always_comb begin
        nxt_base = base_ff;
        nxt_acc = acc_ff;
        nxt_rd = 1'b0;
        if (run) begin
            if (load)
                nxt_base = i_address_in;
            if (cycle == PBSC_DESELECT)
                nxt_acc = 1'b0;
            else if (load)
                nxt_acc = 1'b1;
            // Proc strobe begin is always a read
            if (cycle == PBSC_BEGIN && !ctl.proc_addr_strobe_n
                && !ctl.primary_select_n)
                nxt_rd = 1'b1;
            else if (cycle != PBSC_DESELECT && (load || acc_ff))
                nxt_rd = !wr_req;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            base_ff <= PBSC_ADDR_RST;
            acc_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else begin
            base_ff <= nxt_base;
            acc_ff <= nxt_acc;
            rd_ff <= nxt_rd;
        end
    end

    // ==========================================================
    // Array with byte-lane writes; contents kept across sleep
    logic [31:0] mem [DEPTH];
    logic wr_go;
    logic [31:0] q_ff;
    logic [31:0] nxt_q;

    // Proc strobe begin never writes; others follow the write inputs
    assign wr_go = run && wr_req && cycle != PBSC_DESELECT
                   && (load || acc_ff)
                   && !(load && !ctl.proc_addr_strobe_n
                        && !ctl.primary_select_n);

    // No reset on the array: stored data must persist
    always_ff @(posedge i_clock) begin
        for (int i = 0; i < PBSC_LANES; i++) begin
            if (wr_go && wr_lanes[i])
                mem[addr_now][i*8 +: 8] <= i_data_lane[i*8 +: 8];
        end
    end

    always_comb begin
        nxt_q = q_ff;
        if (nxt_rd)
            nxt_q = mem[addr_now];
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n)
            q_ff <= PBSC_DATA_RST;
        else
            q_ff <= nxt_q;
    end

    // ==========================================================
    // Output drivers: async enable, floated on write/deselect/sleep
    assign o_data_lane = q_ff;
    assign o_data_lane_oe = {PBSC_LANES{rd_ff && !i_output_enable_n
        && !i_sleep_request}};
    assign o_low_power = sleep_ff || i_sleep_request;
    assign o_cycle_type = cycle;

endmodule // pbsc_sram_control

/* File: test/pbsc_sram_control_properties.sv */
// Port-level timing checks for the burst SRAM control block
`timescale 1ns/1ps
module pbsc_sram_control_properties
    import pbsc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_primary_select_n,
    input wire logic i_depth_select_hi,
    input wire logic i_depth_select_lo_n,
    input wire logic i_proc_addr_strobe_n,
    input wire logic i_ctrl_addr_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic i_global_write_n,
    input wire logic i_lane_write_enable_n,
    input wire logic [3:0] i_byte_lane_write_n,
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    input wire logic [3:0] o_data_lane_oe,
    input wire logic o_low_power,
    input wire logic [2:0] o_cycle_type
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // ==========================================================
    // Decoded request classes
    logic sel, wr, nonew, live;
    assign sel = !i_primary_select_n && i_depth_select_hi
        && !i_depth_select_lo_n;
    assign wr = !i_global_write_n
        || (!i_lane_write_enable_n && !(&i_byte_lane_write_n));
    assign nonew = i_ctrl_addr_strobe_n
        && (i_proc_addr_strobe_n || i_primary_select_n);
    assign live = !i_sleep_request;
    sequence rd_begin;
        sel && live && (!i_proc_addr_strobe_n
            || (!i_ctrl_addr_strobe_n && !wr));
    endsequence
    // ==========================================================
    // Decode and drive checks
    ctrl_desel_a: assert property (i_primary_select_n
        && !i_ctrl_addr_strobe_n |-> o_cycle_type == PBSC_DESELECT)
        else $error("ctrl strobe with select off not deselect");
    depth_desel_a: assert property (!i_primary_select_n
        && !i_proc_addr_strobe_n && !(i_depth_select_hi
        && !i_depth_select_lo_n) |-> o_cycle_type == PBSC_DESELECT)
        else $error("depth select off did not deselect");
    depth_ctrl_a: assert property (i_proc_addr_strobe_n
        && !i_ctrl_addr_strobe_n && !(i_depth_select_hi
        && !i_depth_select_lo_n) |-> o_cycle_type == PBSC_DESELECT)
        else $error("ctrl strobe with depth off not deselect");
    begin_code_a: assert property (rd_begin
        |-> o_cycle_type == PBSC_BEGIN) else $error("no begin code");
    oe_gate_a: assert property (i_output_enable_n
        || i_sleep_request |-> o_data_lane_oe == PBSC_LANE_NONE)
        else $error("bus driven while disabled");
    sleep_hold_a: assert property ($past(i_reset_n)
        && $fell(i_sleep_request) |-> o_low_power)
        else $error("low power dropped when sleep fell");
    write_float_a: assert property (wr
        && !(sel && !i_proc_addr_strobe_n)
        |=> o_data_lane_oe == PBSC_LANE_NONE)
        else $error("bus driven after write cycle");
    read_pipe_a: assert property (rd_begin ##1 (live
        && !i_output_enable_n) |-> o_data_lane_oe == PBSC_LANE_ALL)
        else $error("read data not driven one cycle later");
    burst_step_a: assert property (rd_begin ##1 (nonew
        && live) |-> o_cycle_type == (i_burst_advance_n
        ? PBSC_SUSPEND : PBSC_CONTINUE))
        else $error("wrong continue or suspend code");
    desel_float_a: assert property (o_cycle_type
        == PBSC_DESELECT |=> o_data_lane_oe == PBSC_LANE_NONE)
        else $error("bus driven after deselect");
endmodule // pbsc_sram_control_properties

/* File: test/pbsc_master_model.sv */
// Cache controller model: output enable discipline and shared data bus
`timescale 1ns/1ps
module pbsc_master_model
    import pbsc_pkg::*;
(
    input wire logic i_clock,
    input wire pbsc_ctrl_t i_req,
    input wire logic i_oe_n,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] i_dut_data,
    input wire logic [3:0] i_dut_oe,
    output logic o_oe_n,
    output logic [31:0] o_bus
);
    // ==========================================================
    // Write request as the device decodes it
    logic wr;
    logic [31:0] last_ff;
    assign wr = !i_req.global_write_n || (!i_req.lane_write_enable_n
        && i_req.byte_lane_write_n != 4'hf);
    // Enable kept off through any write cycle
    assign o_oe_n = i_oe_n | wr;
    // Released lanes flip, so a stale value never looks valid
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_bus[8*i+:8] = i_dut_oe[i] ? i_dut_data[8*i+:8]
                : (wr ? i_wdata[8*i+:8] : ~last_ff[8*i+:8]);
        end
    end
    always_ff @(posedge i_clock) last_ff <= o_bus;
endmodule // pbsc_master_model

/* File: test/tb_top.sv */
// Directed scenarios for the burst SRAM control block
`timescale 1ns/1ps
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    import pbsc_pkg::*;
    localparam logic [11:0] DS = 12'hb7f, RC = 12'h57f, WG = 12'h55f;
    localparam logic [11:0] CR = 12'h5bf, SR = 12'h5ff, CW = 12'h59f;
    localparam logic [11:0] OPS [5] = '{CR, SR, 12'hbbf, CR, DS};
    localparam int BT [5] = '{0, 1, 1, 2, 3};
    logic i_clock = 0, i_reset_n = 0, oe_n = 1, slp = 0, burst_order_select = 0, lp, gn;
    pbsc_ctrl_t c = DS;
    logic [16:0] a = 0;
    logic [31:0] w = 0, bus, q;
    logic [3:0] lo;
    logic [2:0] ct;
    int bad_count = 0, n_compared = 0;
    always #50 i_clock = ~i_clock;
    pbsc_master_model i_pbsc_master_model (.i_clock(i_clock), .i_req(c),
        .i_oe_n(oe_n), .i_wdata(w), .i_dut_data(q), .i_dut_oe(lo),
        .o_oe_n(gn), .o_bus(bus));
    pbsc_sram_control i_pbsc_sram_control (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .i_primary_select_n(c.primary_select_n),
        .i_depth_select_hi(c.depth_select_hi),
        .i_depth_select_lo_n(c.depth_select_lo_n),
        .i_proc_addr_strobe_n(c.proc_addr_strobe_n),
        .i_ctrl_addr_strobe_n(c.ctrl_addr_strobe_n),
        .i_burst_advance_n(c.burst_advance_n),
        .i_global_write_n(c.global_write_n),
        .i_lane_write_enable_n(c.lane_write_enable_n),
        .i_byte_lane_write_n(c.byte_lane_write_n), .i_address_in(a),
        .i_burst_order_select(burst_order_select), .i_output_enable_n(gn),
        .i_sleep_request(slp), .i_data_lane(bus), .o_data_lane(q),
        .o_data_lane_oe(lo), .o_low_power(lp), .o_cycle_type(ct));
    // One bus cycle, checked once inputs have settled
    task automatic cyc(input logic [11:0] k, input logic [16:0] d = 0,
        input logic [31:0] v = 0);
        @(posedge i_clock);
        c <= k;
        a <= d;
        w <= v;
        #10;
    endtask
    task automatic t_lanes;
        cyc(WG, 17'h3, 32'h11223344);
        cyc({8'h56, 4'he}, 17'h3, 32'haaaaaaaa);
        cyc({8'h56, 4'hf}, 17'h3, 32'h55555555);
        cyc(12'h545, 17'h4, 32'hcafef00d);
        `CMP(q, 32'h112233aa)
        cyc(12'h4df, 17'h4);
        cyc(DS);
        `CMP(q, 32'hcafef00d)
    endtask
    task automatic t_burst(input logic o, input logic [1:0] s);
        @(posedge i_clock);
        burst_order_select <= o;
        cyc(WG, 17'h8, 32'hb0);
        for (int k = 1; k < 4; k++) cyc(CW, 0, 32'hb0 + k);
        cyc(RC, 17'h8 + s);
        foreach (OPS[j]) begin
            logic [1:0] e;
            // Beat offsets wrap modulo four
            e = o ? 2'(s ^ BT[j]) : 2'(s + BT[j]);
            cyc(OPS[j]);
            `CMP(q, 32'hb0 + e)
        end
    endtask
    task automatic t_abort_oe;
        cyc(RC, 17'h8);
        cyc(CR);
        cyc(12'h4ff, 17'h9);
        cyc(CR);
        `CMP(q, 32'hb1)
        `CMP(lo, 4'hf)
        // Enable changed at the edge; a sampled enable would lag a cycle
        @(posedge i_clock);
        oe_n <= 1;
        #10 `CMP(lo, 4'h0)
        `CMP(q, 32'hb0)
        @(posedge i_clock);
        oe_n <= 0;
        #10 `CMP(lo, 4'hf)
        cyc(12'haff);
        `CMP(ct, PBSC_SUSPEND)
        cyc(12'h0ff);
        `CMP(ct, PBSC_DESELECT)
        cyc(12'h6ff);
        `CMP(lo, 4'h0)
    endtask
    task automatic t_sleep;
        @(posedge i_clock);
        slp <= 1;
        #10 `CMP(lp, 1'b1)
        // A write while asleep must not reach the array
        cyc(WG, 17'h3, 32'hdeadbeef);
        cyc(DS);
        @(posedge i_clock);
        slp <= 0;
        cyc(DS);
        `CMP(lp, 1'b1)
        cyc(RC, 17'h3);
        cyc(DS);
        `CMP(q, 32'h112233aa)
        `CMP(lp, 1'b0)
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_reset_n <= 1;
        oe_n <= 0;
        t_lanes;
        for (int s = 0; s < 8; s++) t_burst(s[2], s[1:0]);
        t_abort_oe;
        t_sleep;
        complete_run;
    end
    // Run needs about 120 cycles; allow over twelve times that
    initial begin
        #150000;
        bad_count++;
        complete_run;
    end
endmodule // tb_top
bind pbsc_sram_control pbsc_sram_control_properties i_props (.*);
